// File: rtl/osc_trim_pkg.sv
// Constants shared by the oscillator trim registers and the offset stage.
// Assumes one system clock and an 8-bit register access port.
package osc_trim_pkg;

    // Register addresses
    localparam logic [7:0]  OSC_TRIM_LOW_ADDR  = 8'h3C;
    localparam logic [7:0]  OSC_TRIM_HIGH_ADDR = 8'h3D;

    // Byte and word layout
    localparam int          TRIM_BYTE_W        = 8;
    localparam int          TRIM_WORD_W        = 16;
    localparam int          TRIM_LOW_LSB       = 0;
    localparam int          TRIM_HIGH_LSB      = 8;
    localparam int          OFFSET_W           = 17;
    localparam int          FREQ_W             = 24;

    // Reset values: each byte resets to 1001 1001
    localparam logic [7:0]  OSC_TRIM_BYTE_RESET = 8'h99;
    localparam logic [15:0] OSC_TRIM_ZERO_WORD  = 16'h9999;  // 39321, zero offset

    // Read answer for addresses outside the block
    localparam logic [7:0]  UNMAPPED_READ_DATA  = 8'h00;

    // Trim resolution and usable span
    localparam real         TRIM_STEP_PPM      = 0.0196229;
    localparam real         TRIM_SPAN_POS_PPM  = 514.0;
    localparam real         TRIM_SPAN_NEG_PPM  = 771.0;

    // Signed offset bounds that the 16-bit word can reach
    localparam logic signed [16:0] OFFSET_MAX = 17'sh06666;  // 65535 - 39321
    localparam logic signed [16:0] OFFSET_MIN = -17'sh09999; // 0 - 39321

endpackage

// File: rtl/trim_offset_calc.sv
// Converts the unsigned trim word into a signed offset in trim steps.
// Assumes the word comes from registers on the same clock; purely combinational.
`timescale 1ns/1ps

module trim_offset_calc
    import osc_trim_pkg::*;
(
    trim_word,
    trim_offset,
    at_pos_limit,
    at_neg_limit
);
    input  wire logic        [15:0] trim_word;
    output logic signed      [16:0] trim_offset;
    output logic                    at_pos_limit;
    output logic                    at_neg_limit;

    // Offset is the stored word less the zero-offset default
    always_comb
    begin
        trim_offset  = $signed({1'b0, trim_word}) - $signed({1'b0, OSC_TRIM_ZERO_WORD});
        at_pos_limit = (trim_offset == OFFSET_MAX);
        at_neg_limit = (trim_offset == OFFSET_MIN);
    end

endmodule

// File: rtl/reference_oscillator_trim.sv
// Oscillator trim register pair and the trimmed loop frequency report.
// Assumes the serial configuration port has already been decoded into
// single-cycle read and write strobes on clk, and that the loop filter
// supplies its raw frequency on the same clock.
// Nothing stalls: a request is taken at every edge it is seen.
// Writes to other addresses are ignored; reads there answer 0x00.
`timescale 1ns/1ps

module reference_oscillator_trim
    import osc_trim_pkg::*;
(
    clk,
    sys_rst,
    reg_addr,
    reg_wr_en,
    reg_wr_data,
    reg_rd_en,
    reg_rd_data,
    reg_rd_valid,
    raw_loop_freq,
    trim_word,
    trim_offset,
    reported_loop_freq,
    trim_updated,
    trim_at_pos_limit,
    trim_at_neg_limit
);
    input  wire logic               clk;
    input  wire logic               sys_rst;
    input  wire logic        [7:0]  reg_addr;
    input  wire logic               reg_wr_en;
    input  wire logic        [7:0]  reg_wr_data;
    input  wire logic               reg_rd_en;
    output logic             [7:0]  reg_rd_data;
    output logic                    reg_rd_valid;
    input  wire logic signed [23:0] raw_loop_freq;
    output logic             [15:0] trim_word;
    output logic signed      [16:0] trim_offset;
    output logic signed      [23:0] reported_loop_freq;
    output logic                    trim_updated;
    output logic                    trim_at_pos_limit;
    output logic                    trim_at_neg_limit;

    // Register state
    logic        [7:0]  osc_trim_low_reg;
    logic        [7:0]  osc_trim_low_next;
    logic        [7:0]  osc_trim_high_reg;
    logic        [7:0]  osc_trim_high_next;
    logic        [7:0]  rd_data_reg;
    logic        [7:0]  rd_data_next;
    logic               rd_valid_reg;
    logic               rd_valid_next;
    logic               updated_reg;
    logic               updated_next;

    // Derived state
    // Limit flags are levels; they clear one edge after the word moves away
    logic signed [16:0] offset_reg;
    logic signed [16:0] offset_next;
    logic signed [23:0] reported_reg;
    logic signed [23:0] reported_next;
    logic               pos_limit_reg;
    logic               pos_limit_next;
    logic               neg_limit_reg;
    logic               neg_limit_next;

    // Combined word seen by the loop
    logic        [15:0] word_now;
    logic signed [16:0] offset_now;
    logic               pos_limit_now;
    logic               neg_limit_now;

    // Either byte feeds the word directly; no shadow or commit stage
    assign word_now = {osc_trim_high_reg, osc_trim_low_reg};

    // Offset and limit decode carry no register of their own; the stage
    // further down registers them so every output leaves a flip-flop.
    trim_offset_calc trim_offset_calc_inst
    (
        .trim_word    (word_now),
        .trim_offset  (offset_now),
        .at_pos_limit (pos_limit_now),
        .at_neg_limit (neg_limit_now)
    );

    // Register writes and reads
    always_comb
    begin
        osc_trim_low_next  = osc_trim_low_reg;
        osc_trim_high_next = osc_trim_high_reg;
        updated_next       = 1'b0;
        rd_data_next       = rd_data_reg;
        rd_valid_next      = 1'b0;
        // Only the two trim addresses are decoded; the rest of the map is
        // served by other blocks.
        if (reg_wr_en)
        begin
            case (reg_addr)
                OSC_TRIM_LOW_ADDR:
                begin
                    osc_trim_low_next = reg_wr_data;
                    updated_next      = 1'b1;
                end
                OSC_TRIM_HIGH_ADDR:
                begin
                    osc_trim_high_next = reg_wr_data;
                    updated_next       = 1'b1;
                end
                default:
                begin
                    updated_next = 1'b0;  // Other addresses belong elsewhere
                end
            endcase
        end
        // Reads sample the bytes before this edge's write lands, so a read
        // and a write of one byte in the same cycle return the old value.
        if (reg_rd_en)
        begin
            rd_valid_next = 1'b1;
            case (reg_addr)
                OSC_TRIM_LOW_ADDR:
                begin
                    rd_data_next = osc_trim_low_reg;
                end
                OSC_TRIM_HIGH_ADDR:
                begin
                    rd_data_next = osc_trim_high_reg;
                end
                default:
                begin
                    rd_data_next = UNMAPPED_READ_DATA;
                end
            endcase
        end
    end

    // Reset restores the zero-offset word; the loop sees it from the
    // first edge after release.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            osc_trim_low_reg  <= OSC_TRIM_BYTE_RESET;
            osc_trim_high_reg <= OSC_TRIM_BYTE_RESET;
            updated_reg       <= 1'b0;
            rd_data_reg       <= 8'h00;
            rd_valid_reg      <= 1'b0;
        end
        else
        begin
            osc_trim_low_reg  <= osc_trim_low_next;
            osc_trim_high_reg <= osc_trim_high_next;
            updated_reg       <= updated_next;
            rd_data_reg       <= rd_data_next;
            rd_valid_reg      <= rd_valid_next;
        end
    end

    // Trimmed frequency report. The offset is counted in steps of
    // TRIM_STEP_PPM, the same unit as the raw loop frequency, so the sum
    // needs no scaling. Saturation guards against a raw value near the
    // edge of its range wrapping when the full span is programmed.
    always_comb
    begin
        logic signed [24:0] sum;
        sum            = 25'sh0;
        offset_next    = offset_now;
        pos_limit_next = pos_limit_now;
        neg_limit_next = neg_limit_now;
        sum = $signed({raw_loop_freq[23], raw_loop_freq})
            + $signed({{8{offset_now[16]}}, offset_now});
        if (sum > 25'sh7FFFFF)
        begin
            reported_next = 24'sh7FFFFF;
        end
        else if (sum < -25'sh800000)
        begin
            reported_next = 24'sh800000; // Most negative 24-bit value
        end
        else
        begin
            reported_next = sum[23:0];
        end
    end

    // One register stage keeps offset, flags and report in step, all
    // landing two edges after the write strobe.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            offset_reg    <= 17'sh00000;
            reported_reg  <= 24'sh000000;
            pos_limit_reg <= 1'b0;
            neg_limit_reg <= 1'b0;
        end
        else
        begin
            offset_reg    <= offset_next;
            reported_reg  <= reported_next;
            pos_limit_reg <= pos_limit_next;
            neg_limit_reg <= neg_limit_next;
        end
    end

    // Outputs, all straight from flip-flops
    // trim_word is the byte pair itself, so it leads trim_offset by one edge
    assign trim_word          = {osc_trim_high_reg, osc_trim_low_reg};
    assign trim_offset        = offset_reg;
    assign reported_loop_freq = reported_reg;
    assign trim_updated       = updated_reg;
    assign trim_at_pos_limit  = pos_limit_reg;
    assign trim_at_neg_limit  = neg_limit_reg;
    assign reg_rd_data        = rd_data_reg;
    assign reg_rd_valid       = rd_valid_reg;

endmodule

// File: testbench/reference_oscillator_trim_assertions.sv
// Checker for the oscillator trim registers, watching top-level ports only.
// Assumes one clock and synchronous active-high reset; attached by bind.
`timescale 1ns/1ps
module reference_oscillator_trim_assertions
    import osc_trim_pkg::*;
(
    input logic               clk,
    input logic               sys_rst,
    input logic        [7:0]  reg_addr,
    input logic               reg_wr_en,
    input logic        [7:0]  reg_wr_data,
    input logic               reg_rd_en,
    input logic        [7:0]  reg_rd_data,
    input logic               reg_rd_valid,
    input logic signed [23:0] raw_loop_freq,
    input logic        [15:0] trim_word,
    input logic signed [16:0] trim_offset,
    input logic signed [23:0] reported_loop_freq,
    input logic               trim_updated,
    input logic               trim_at_pos_limit,
    input logic               trim_at_neg_limit
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Each byte lands in its own half of the word on the next edge
    AST_WR_LOW:
        assert property (reg_wr_en && reg_addr == 8'h3C |=> trim_word[7:0] == $past(reg_wr_data))
        else $error("low byte write lost");
    AST_WR_HIGH:
        assert property (reg_wr_en && reg_addr == 8'h3D |=> trim_word[15:8] == $past(reg_wr_data))
        else $error("high byte write lost");
    AST_HOLD:
        assert property (!(reg_wr_en && reg_addr[7:1] == 7'h1E) |=> $stable(trim_word))
        else $error("trim word moved without a write");
    AST_RD_LOW:
        assert property (reg_rd_en && reg_addr == 8'h3C |=> reg_rd_data == $past(trim_word[7:0]))
        else $error("low byte read mismatch");
    AST_RD_VALID:
        assert property (reg_rd_en |=> reg_rd_valid ##1 (!reg_rd_valid || $past(reg_rd_en)))
        else $error("read valid missing");
    AST_OFFSET:
        assert property (trim_offset == $signed({1'b0, $past(trim_word)}) - 17'sd39321)
        else $error("offset not word minus default");
    // Saturation is left out by bounding the raw input; the report and
    // trim_offset land on the same edge, so the current offset is used
    AST_REPORT:
        assert property (raw_loop_freq < 24'sh100000 && raw_loop_freq > -24'sh100000
            |=> reported_loop_freq == $past(raw_loop_freq) + 24'(trim_offset))
        else $error("reported frequency lacks trim");
    AST_POS_LIMIT:
        assert property (trim_at_pos_limit == ($past(trim_word) == 16'hFFFF))
        else $error("positive limit flag wrong");
    AST_NEG_LIMIT:
        assert property (trim_at_neg_limit == ($past(trim_word) == 16'h0000))
        else $error("negative limit flag wrong");
    // Update pulse follows exactly the trim byte writes
    AST_UPDATED:
        assert property (trim_updated == $past(reg_wr_en && reg_addr[7:1] == 7'h1E))
        else $error("update pulse wrong");
endmodule
bind reference_oscillator_trim reference_oscillator_trim_assertions checker_inst (.*);

// File: testbench/reference_oscillator_trim_test.sv
// Self-checking bench for the oscillator trim register pair.
// Drives every input on the falling edge; no partner model.
`timescale 1ns/1ps
module reference_oscillator_trim_test;
    import osc_trim_pkg::*;
    logic               clk = 1'b0;
    logic               sys_rst = 1'b1;
    logic        [7:0]  reg_addr = 8'h00;
    logic               reg_wr_en = 1'b0;
    logic        [7:0]  reg_wr_data = 8'h00;
    logic               reg_rd_en = 1'b0;
    logic signed [23:0] raw_loop_freq = 24'sh000000;
    logic        [7:0]  reg_rd_data;
    logic               reg_rd_valid;
    logic        [15:0] trim_word;
    logic signed [16:0] trim_offset;
    logic signed [23:0] reported_loop_freq;
    logic               trim_updated;
    logic               trim_at_pos_limit;
    logic               trim_at_neg_limit;
    int                 miscompares = 0;
    int                 checks_done = 0;
    reference_oscillator_trim reference_oscillator_trim_inst (.*);
    // 4 ns period
    always #2 clk = ~clk;
    task automatic tally_and_finish;
        if (miscompares == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Write strobe is one cycle; waits until offset and flags have landed
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wr_data = d;
        reg_wr_en = 1'b1;
        @(negedge clk);
        reg_wr_en = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    // Bounded wait for the valid pulse so a silent design cannot hang the run
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        int n;
        @(negedge clk);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge clk);
        reg_rd_en = 1'b0;
        for (n = 0; n < 4 && reg_rd_valid !== 1'b1; n++)
            @(negedge clk);
        if (n == 4)
        begin
            miscompares++;
            $display("wrong value at %0t: no read valid", $time);
            tally_and_finish();
        end
        else
            check(reg_rd_data, exp);
    endtask
    task automatic reset_values;
        check(trim_word, 16'h9999);
        check(trim_offset, 17'h00000);
        rd(8'h3C, 8'h99);
        rd(8'h3D, 8'h99);
    endtask
    task automatic byte_writes;
        wr(8'h3C, 8'h00);
        check(trim_word, 16'h9900);
        check(trim_offset, -17'sd153);
        rd(8'h3C, 8'h00);
        wr(8'h3D, 8'h12);
        check(trim_word, 16'h1200);
    endtask
    task automatic limits;
        wr(8'h3D, 8'h00);
        check(trim_offset, -17'sd39321);
        check(trim_at_neg_limit, 1'b1);
        wr(8'h3C, 8'hFF);
        wr(8'h3D, 8'hFF);
        check(trim_offset, 17'sd26214);
        check(trim_at_pos_limit, 1'b1);
    endtask
    // Second step drives the sum past the top so the clamp is exercised
    task automatic freq_report;
        raw_loop_freq = -24'sd1000;
        repeat (2) @(negedge clk);
        check(reported_loop_freq, 24'sd25214);
        raw_loop_freq = 24'sh7FFFF0;
        repeat (2) @(negedge clk);
        check(reported_loop_freq, 24'sh7FFFFF);
        raw_loop_freq = 24'sh000000;
    endtask
    task automatic unmapped;
        wr(8'h3E, 8'h55);
        check(trim_word, 16'hFFFF);
        rd(8'h3E, 8'h00);
    endtask
    // Strobe stands for one edge only, so the pulse is caught at the next fall
    task automatic update_pulse;
        @(negedge clk);
        reg_addr = 8'h3C;
        reg_wr_data = 8'hAA;
        reg_wr_en = 1'b1;
        @(negedge clk);
        reg_wr_en = 1'b0;
        check(trim_updated, 1'b1);
        check(trim_word, 16'hFFAA);
        @(negedge clk);
        check(trim_updated, 1'b0);
    endtask
    // Main sequence
    initial
    begin
        repeat (5) @(negedge clk);
        sys_rst = 1'b0;
        reset_values();
        byte_writes();
        limits();
        freq_report();
        unmapped();
        update_pulse();
        tally_and_finish();
    end
endmodule
